// ---- hdl/ptlc_top.sv ----
// pattern trigger sequencing, exposure triggers, status leds and led driver control
//
// Overview of operation
// - An edge on the advance trigger steps to the next pattern or alternates two patterns, by mode.
// - An edge on the pause trigger pauses or resumes the sequence or advances it by two patterns, by mode.
// - The exposure trigger output is high exactly while a pattern is being exposed.
// - The first pattern trigger output is high while pattern zero of the sequence is shown.
// - The alive indicator toggles steadily while no fault is present, so its led blinks.
// - The fault indicator led is lit when there is no fault and turned off on a fault.
// - Up to three led channels, red, green and blue, each get their own enable output.
// - Each colour channel gets its own pwm output whose duty sets that led's current.
// - Driver enable, per-led enables, led enable selection and pwm are distinct outputs.
// - The outside supplies the reference clock and all timing here is derived from it.
// - Line and frame sync join the triggers in deciding when patterns advance and expose.
`timescale 1ns/10ps
module ptlc_top
  import ptlc_pkg::*;
#(
  parameter int ALIVE_HALF_CYCLES = ALIVE_HALF_CYC
)
(
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          advance_trigger_in_i,
  input  wire logic                          pause_trigger_in_i,
  input  wire logic                          line_sync_in_i,
  input  wire logic                          frame_sync_in_i,
  input  wire logic                          seq_run_i,
  input  wire logic                          adv_mode_i,
  input  wire logic                          pau_mode_i,
  input  wire logic                          frame_advance_i,
  input  wire logic                          line_lock_i,
  input  wire logic [IDX_W-1:0]              pattern_count_i,
  input  wire logic [EXP_W-1:0]              exposure_cycles_i,
  input  wire logic                          fault_i,
  input  wire logic                          led_driver_enable_i,
  input  wire logic [LED_CH-1:0]             led_select_i,
  input  wire logic [LED_CH-1:0][DUTY_W-1:0] led_duty_i,
  output logic      [IDX_W-1:0]              pattern_index_o,
  output logic                               seq_paused_o,
  output logic                               exposure_trigger_out_o,
  output logic                               first_pattern_trigger_out_o,
  output logic                               alive_indicator_o,
  output logic                               fault_indicator_o,
  output logic                               led_driver_enable_o,
  output logic      [LED_CH-1:0]             led_enable_select_o,
  output logic                               red_led_enable_o,
  output logic                               green_led_enable_o,
  output logic                               blue_led_enable_o,
  output logic                               red_current_pwm_o,
  output logic                               green_current_pwm_o,
  output logic                               blue_current_pwm_o
);
  // ----------------------------------------------------------------
  // input synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] sync_q;
  logic [3:0] pin_in;
  logic [3:0] pin_edge;
  assign pin_in   = {frame_sync_in_i, line_sync_in_i, pause_trigger_in_i, advance_trigger_in_i};
  assign pin_edge = sync_b & ~sync_q;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      sync_q <= 4'h0;
    end
    else
    begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      sync_q <= sync_b;
    end
  end

  // ----------------------------------------------------------------
  // sequencer decode
  // ----------------------------------------------------------------
  ptlc_state_t      state;
  ptlc_state_t      next_state;
  logic [EXP_W-1:0] exp_cnt;
  logic [EXP_W-1:0] next_exp_cnt;
  logic [EXP_W-1:0] exp_len;
  logic [IDX_W-1:0] next_index;
  logic [IDX_W-1:0] seq_len;
  logic             paused;
  logic             next_paused;
  logic             adv_ok;
  logic             step_evt;
  logic             alt_evt;
  logic             two_evt;
  logic             pause_evt;
  logic             any_adv;
  logic             line_evt;

  function automatic logic [IDX_W-1:0] wrap_idx(input logic [IDX_W:0] s,
                                                input logic [IDX_W-1:0] n);
    logic [IDX_W:0] v;
    v = s;
    if (v >= {1'b0, n})
      v = v - {1'b0, n};
    if (v >= {1'b0, n})
      v = v - {1'b0, n};
    return v[IDX_W-1:0];
  endfunction

  assign seq_len   = (pattern_count_i == IDX_ZERO) ? IDX_ONE : pattern_count_i;
  assign exp_len   = (exposure_cycles_i == '0) ? EXP_ONE : exposure_cycles_i;
  assign adv_ok    = seq_run_i & ~paused;
  assign step_evt  = adv_ok & ((pin_edge[0] & (adv_mode_i == ADV_MODE_STEP))
                   | (pin_edge[3] & frame_advance_i));
  assign alt_evt   = adv_ok & pin_edge[0] & (adv_mode_i == ADV_MODE_ALTERNATE);
  assign two_evt   = adv_ok & pin_edge[1] & (pau_mode_i == PAU_MODE_SKIP_TWO);
  assign pause_evt = seq_run_i & pin_edge[1] & (pau_mode_i == PAU_MODE_PAUSE);
  assign any_adv   = step_evt | alt_evt | two_evt;
  assign line_evt  = pin_edge[2];
  assign next_paused = seq_run_i & (paused ^ pause_evt);

  assign next_index =
      !seq_run_i ? IDX_ZERO :
      two_evt    ? wrap_idx({1'b0, pattern_index_o} + {1'b0, IDX_TWO}, seq_len) :
      alt_evt    ? ((pattern_index_o == IDX_ZERO) ? IDX_ONE : IDX_ZERO) :
      step_evt   ? wrap_idx({1'b0, pattern_index_o} + {1'b0, IDX_ONE}, seq_len) :
                   pattern_index_o;

  assign next_state =
      !seq_run_i                        ? SEQ_IDLE :
      any_adv                           ? (line_lock_i ? SEQ_WAIT : SEQ_EXPOSE) :
      (state == SEQ_WAIT && line_evt)   ? SEQ_EXPOSE :
      (state == SEQ_EXPOSE && exp_cnt == EXP_ONE) ? SEQ_IDLE :
                                          state;

  assign next_exp_cnt =
      (next_state == SEQ_EXPOSE && state != SEQ_EXPOSE) ? exp_len :
      (any_adv && next_state == SEQ_EXPOSE)             ? exp_len :
      (state == SEQ_EXPOSE)                             ? exp_cnt - EXP_ONE :
                                                          exp_cnt;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state                       <= SEQ_IDLE;
      exp_cnt                     <= '0;
      paused                      <= 1'b0;
      pattern_index_o             <= IDX_ZERO;
      seq_paused_o                <= 1'b0;
      exposure_trigger_out_o      <= 1'b0;
      first_pattern_trigger_out_o <= 1'b0;
    end
    else
    begin
      state                       <= next_state;
      exp_cnt                     <= next_exp_cnt;
      paused                      <= next_paused;
      pattern_index_o             <= next_index;
      seq_paused_o                <= next_paused;
      exposure_trigger_out_o      <= (next_state == SEQ_EXPOSE);
      first_pattern_trigger_out_o <= seq_run_i & (next_index == IDX_ZERO);
    end
  end

  // ----------------------------------------------------------------
  // status indicators
  // ----------------------------------------------------------------
  logic [ALIVE_CNT_W-1:0] alive_cnt;
  logic                   alive_wrap;
  assign alive_wrap = (alive_cnt == ALIVE_CNT_W'(ALIVE_HALF_CYCLES - 1));

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      alive_cnt         <= '0;
      alive_indicator_o <= 1'b0;
      fault_indicator_o <= 1'b0;
    end
    else
    begin
      alive_cnt         <= (alive_wrap || fault_i) ? '0 : alive_cnt + 1'b1;
      alive_indicator_o <= alive_indicator_o ^ (alive_wrap & ~fault_i);
      fault_indicator_o <= ~fault_i;
    end
  end

  // ----------------------------------------------------------------
  // led driver control and current pwm
  // ----------------------------------------------------------------
  logic [PWM_DIV_W-1:0] pwm_div;
  logic                 pwm_tick;
  logic [DUTY_W-1:0]    pwm_cnt;
  logic [LED_CH-1:0]    led_en;
  logic [LED_CH-1:0]    led_pwm;
  logic [LED_CH-1:0]    next_led_en;
  logic [LED_CH-1:0]    next_pwm;
  assign pwm_tick = (pwm_div == PWM_DIV_W'(PWM_TICK_CYC - 1));

  generate
    for (genvar ch = 0; ch < LED_CH; ch++)
    begin : g_ch
      assign next_led_en[ch] = led_driver_enable_i & led_select_i[ch]
                             & (next_state == SEQ_EXPOSE);
      assign next_pwm[ch]    = led_driver_enable_i & (pwm_cnt < led_duty_i[ch]);
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pwm_div             <= '0;
      pwm_cnt             <= '0;
      led_en              <= '0;
      led_pwm             <= '0;
      led_driver_enable_o <= 1'b0;
      led_enable_select_o <= '0;
    end
    else
    begin
      pwm_div             <= pwm_tick ? '0 : pwm_div + 1'b1;
      pwm_cnt             <= pwm_cnt + DUTY_W'(pwm_tick);
      led_en              <= next_led_en;
      led_pwm             <= next_pwm;
      led_driver_enable_o <= led_driver_enable_i;
      led_enable_select_o <= led_select_i;
    end
  end

  assign red_led_enable_o    = led_en[CH_RED];
  assign green_led_enable_o  = led_en[CH_GREEN];
  assign blue_led_enable_o   = led_en[CH_BLUE];
  assign red_current_pwm_o   = led_pwm[CH_RED];
  assign green_current_pwm_o = led_pwm[CH_GREEN];
  assign blue_current_pwm_o  = led_pwm[CH_BLUE];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic [EXP_W-1:0] hi_cnt;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      hi_cnt <= '0;
    else
      hi_cnt <= (exposure_trigger_out_o && !any_adv) ? hi_cnt + 1'b1 : '0;
  end

  sequence s_pin_rise;
    !advance_trigger_in_i ##1 advance_trigger_in_i [*3];
  endsequence

  a_trig_sync_edge: assert property (s_pin_rise |-> $past(pin_edge[0], 1) || pin_edge[0])
    else $error("advance trigger edge not seen after synchroniser");
  a_step_next_idx: assert property ((step_evt && !alt_evt && !two_evt && seq_len > IDX_TWO
      && pattern_index_o == IDX_ZERO) |=> pattern_index_o == IDX_ONE)
    else $error("step did not move to the next pattern");
  a_alt_toggle: assert property ((alt_evt && !two_evt && pattern_index_o == IDX_ONE) |=>
      pattern_index_o == IDX_ZERO)
    else $error("alternate mode did not return to pattern zero");
  a_pause_holds: assert property ((paused && seq_run_i) ##1 (seq_run_i && !pause_evt)
      |-> $stable(pattern_index_o))
    else $error("pattern index moved while paused");
  a_skip_two: assert property ((two_evt && seq_len > IDX_TWO
      && pattern_index_o < seq_len - IDX_TWO)
      |=> pattern_index_o == $past(pattern_index_o) + IDX_TWO)
    else $error("skip mode did not advance by two");
  a_exposure_len: assert property ($fell(exposure_trigger_out_o) && $past(seq_run_i)
      && !$past(any_adv) && $stable(exposure_cycles_i) && exposure_cycles_i > EXP_ONE
      && $past(hi_cnt) != '0 |-> $past(hi_cnt) == exposure_cycles_i - EXP_ONE)
    else $error("exposure pulse length differs from programmed count");
  a_first_flag: assert property (first_pattern_trigger_out_o ==
      ($past(seq_run_i) && pattern_index_o == IDX_ZERO))
    else $error("first pattern output disagrees with pattern index");
  a_alive_frozen: assert property (fault_i ##1 fault_i |-> $stable(alive_indicator_o))
    else $error("alive indicator toggled during a fault");
  a_fault_led: assert property ($past(rstn_i) |-> fault_indicator_o == !$past(fault_i))
    else $error("fault led does not follow the fault one cycle late");
  a_led_gate: assert property ((red_led_enable_o || green_led_enable_o || blue_led_enable_o)
      |-> exposure_trigger_out_o && led_driver_enable_o)
    else $error("colour enable outside exposure or with driver off");
  a_pwm_zero: assert property ($past(led_duty_i[CH_RED]) == '0 |-> !red_current_pwm_o)
    else $error("red pwm high with zero duty");
endmodule

// ---- hdl/ptlc_pkg.sv ----
// constants and types shared by the pattern trigger and led control block
package ptlc_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int ALIVE_HALF_MS   = 250;
  localparam int ALIVE_HALF_CYC  = ALIVE_HALF_MS * 1000 * CLK_MHZ;
  localparam int ALIVE_CNT_W     = 25;
  localparam int PWM_TICK_NS     = 40;
  localparam int PWM_TICK_CYC    = (PWM_TICK_NS * CLK_MHZ + 999) / 1000;
  localparam int PWM_DIV_W       = 3;
  // ----------------------------------------------------------------
  // widths and layout
  // ----------------------------------------------------------------
  localparam int IDX_W           = 6;
  localparam int EXP_W           = 16;
  localparam int DUTY_W          = 8;
  localparam int LED_CH          = 3;
  localparam int CH_RED          = 0;
  localparam int CH_GREEN        = 1;
  localparam int CH_BLUE         = 2;
  localparam logic [IDX_W-1:0] IDX_ZERO = 6'h00;
  localparam logic [IDX_W-1:0] IDX_ONE  = 6'h01;
  localparam logic [IDX_W-1:0] IDX_TWO  = 6'h02;
  localparam logic [EXP_W-1:0] EXP_ONE  = 16'h0001;
  // ----------------------------------------------------------------
  // trigger modes and sequencer states
  // ----------------------------------------------------------------
  localparam logic ADV_MODE_STEP      = 1'b0;
  localparam logic ADV_MODE_ALTERNATE = 1'b1;
  localparam logic PAU_MODE_PAUSE     = 1'b0;
  localparam logic PAU_MODE_SKIP_TWO  = 1'b1;
  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_WAIT   = 2'b01,
    SEQ_EXPOSE = 2'b10
  } ptlc_state_t;
endpackage

// ---- testbench/ptlc_camera.sv ----
// camera model: drives trigger and sync pins and times exposure pulses
`timescale 1ns/10ps
module ptlc_camera
(
  input  wire logic        clk_i,
  input  wire logic        exposing_i,
  output logic             advance_o,
  output logic             pause_o,
  output logic             line_o,
  output logic             frame_o,
  output logic [15:0]      width_o,
  output logic [15:0]      count_o
);
  logic [3:0]  pins    = 4'h0;
  logic [15:0] run_cnt = 16'h0000;
  logic [15:0] width   = 16'h0000;
  logic [15:0] n_seen  = 16'h0000;
  assign {frame_o, line_o, pause_o, advance_o} = pins;
  assign width_o = width;
  assign count_o = n_seen;
  // pins are pushed and released just after a clock edge, low at least two cycles between
  task automatic pulse(input int which);
    repeat (2) @(posedge clk_i);
    pins[which] <= 1'b1;
    repeat (3) @(posedge clk_i);
    pins[which] <= 1'b0;
  endtask
  // width of the last finished exposure pulse, in clock cycles
  always @(posedge clk_i)
  begin
    if (exposing_i)
      run_cnt <= run_cnt + 16'h0001;
    else if (run_cnt != 16'h0000)
    begin
      width   <= run_cnt;
      n_seen  <= n_seen + 16'h0001;
      run_cnt <= 16'h0000;
    end
  end
endmodule

// ---- testbench/test_ptlc_top.sv ----
// self-checking bench for the pattern trigger and led control block
`timescale 1ns/10ps
module test_ptlc_top;
  import ptlc_pkg::*;
  localparam int AH = 8;
  logic                          clk_i = 1'b0;
  logic                          rstn_i = 1'b0;
  logic                          run, amode, pmode, fadv;
  logic                          llock, fault, drv;
  logic [LED_CH-1:0]             sel;
  logic [LED_CH-1:0][DUTY_W-1:0] duty;
  logic [IDX_W-1:0]              pcnt;
  logic [EXP_W-1:0]              expc;
  logic                          adv, pau, lin, frm, paused, expo, first, alive, fled, drv_o;
  logic                          r_en, g_en, b_en, r_pw, g_pw, b_pw;
  logic [IDX_W-1:0]              pidx;
  logic [LED_CH-1:0]             sel_o;
  logic [15:0]                   width, nexp;
  int                            n_mismatch = 0;
  int                            tests_run = 0;
  always #5 clk_i = ~clk_i;
  ptlc_top #(.ALIVE_HALF_CYCLES(AH)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .advance_trigger_in_i(adv), .pause_trigger_in_i(pau), .line_sync_in_i(lin),
    .frame_sync_in_i(frm), .seq_run_i(run), .adv_mode_i(amode), .pau_mode_i(pmode),
    .frame_advance_i(fadv), .line_lock_i(llock), .pattern_count_i(pcnt),
    .exposure_cycles_i(expc), .fault_i(fault), .led_driver_enable_i(drv),
    .led_select_i(sel), .led_duty_i(duty), .pattern_index_o(pidx), .seq_paused_o(paused),
    .exposure_trigger_out_o(expo), .first_pattern_trigger_out_o(first),
    .alive_indicator_o(alive), .fault_indicator_o(fled), .led_driver_enable_o(drv_o),
    .led_enable_select_o(sel_o), .red_led_enable_o(r_en), .green_led_enable_o(g_en),
    .blue_led_enable_o(b_en), .red_current_pwm_o(r_pw), .green_current_pwm_o(g_pw),
    .blue_current_pwm_o(b_pw));
  ptlc_camera cam (.clk_i(clk_i), .exposing_i(expo), .advance_o(adv), .pause_o(pau),
    .line_o(lin), .frame_o(frm), .width_o(width), .count_o(nexp));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wait_exp();
    int k;
    k = 0;
    @(negedge clk_i);
    while (expo !== 1'b1 && k < 20)
    begin
      @(negedge clk_i);
      k++;
    end
    chk("exposure start", 16'h0001, {15'h0, expo});
  endtask
  task automatic step_to(input logic [IDX_W-1:0] idx);
    wait_exp();
    chk("index", {10'h0, idx}, {10'h0, pidx});
    cyc(2);
    chk("first pattern", {15'h0, idx == IDX_ZERO}, {15'h0, first});
    cyc(6);
    chk("exposure width", expc, width);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_step();
    @(posedge clk_i);
    run <= 1'b1;
    drv <= 1'b1;
    sel <= 3'h5;
    cyc(4);
    chk("first at start", 16'h0001, {15'h0, first});
    cam.pulse(0);
    wait_exp();
    cyc(2);
    chk("red enable", 16'h0001, {15'h0, r_en});
    chk("green enable", 16'h0000, {15'h0, g_en});
    chk("blue enable", 16'h0001, {15'h0, b_en});
    cyc(6);
    chk("red enable off", 16'h0000, {15'h0, r_en});
    chk("step index", 16'h0001, {10'h0, pidx});
    for (int i = 2; i <= 4; i++)
    begin
      cam.pulse(0);
      step_to(6'(i % 4));
    end
  endtask
  task automatic t_alt();
    @(posedge clk_i);
    amode <= ADV_MODE_ALTERNATE;
    for (int i = 1; i <= 3; i++)
    begin
      cam.pulse(0);
      step_to(6'(i % 2));
    end
    @(posedge clk_i);
    amode <= ADV_MODE_STEP;
  endtask
  task automatic t_pause();
    logic [15:0] n0;
    cam.pulse(1);
    cyc(6);
    chk("paused", 16'h0001, {15'h0, paused});
    n0 = nexp;
    cam.pulse(0);
    cyc(12);
    chk("index held", 16'h0001, {10'h0, pidx});
    chk("no exposure", n0, nexp);
    cam.pulse(1);
    cyc(6);
    chk("resumed", 16'h0000, {15'h0, paused});
    @(posedge clk_i);
    pmode <= PAU_MODE_SKIP_TWO;
    cam.pulse(1);
    cyc(10);
    chk("skip two", 16'h0003, {10'h0, pidx});
    cam.pulse(1);
    cyc(10);
    chk("skip two wrap", 16'h0001, {10'h0, pidx});
    @(posedge clk_i);
    pmode <= PAU_MODE_PAUSE;
  endtask
  task automatic t_sync();
    logic [15:0] n0;
    @(posedge clk_i);
    fadv <= 1'b1;
    expc <= 16'h0003;
    cam.pulse(3);
    step_to(6'h02);
    @(posedge clk_i);
    fadv <= 1'b0;
    llock <= 1'b1;
    n0 = nexp;
    cam.pulse(0);
    cyc(12);
    chk("exposure waits line", 16'h0000, {15'h0, expo});
    chk("no early exposure", n0, nexp);
    cam.pulse(2);
    step_to(6'h03);
    @(posedge clk_i);
    llock <= 1'b0;
  endtask
  task automatic t_status();
    logic a0;
    int   k;
    a0 = alive;
    k = 0;
    while (alive === a0 && k < 30)
    begin
      cyc(1);
      k++;
    end
    a0 = alive;
    k = 0;
    while (alive === a0 && k < 30)
    begin
      cyc(1);
      k++;
    end
    chk("alive half period", 16'(AH), 16'(k));
    @(posedge clk_i);
    fault <= 1'b1;
    cyc(3);
    chk("fault led off", 16'h0000, {15'h0, fled});
    a0 = alive;
    k = 0;
    repeat (20)
    begin
      cyc(1);
      if (alive !== a0)
        k++;
      a0 = alive;
    end
    chk("alive toggles in fault", 16'h0000, 16'(k));
    @(posedge clk_i);
    fault <= 1'b0;
    cyc(3);
    chk("fault led lit", 16'h0001, {15'h0, fled});
  endtask
  task automatic t_pwm();
    logic [15:0] nr, ng, nb;
    nr = 16'h0000;
    ng = 16'h0000;
    nb = 16'h0000;
    @(posedge clk_i);
    duty <= {8'hff, 8'h00, 8'h40};
    cyc(20);
    chk("driver enable", 16'h0001, {15'h0, drv_o});
    chk("enable select", 16'h0005, {13'h0, sel_o});
    repeat (1024)
    begin
      cyc(1);
      nr = nr + {15'h0, r_pw};
      ng = ng + {15'h0, g_pw};
      nb = nb + {15'h0, b_pw};
    end
    chk("red pwm high", 16'h0100, nr);
    chk("green pwm high", 16'h0000, ng);
    chk("blue pwm high", 16'h03fc, nb);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    @(posedge clk_i);
    run    <= 1'b0;
    amode  <= ADV_MODE_STEP;
    pmode  <= PAU_MODE_PAUSE;
    fadv   <= 1'b0;
    llock  <= 1'b0;
    fault  <= 1'b0;
    drv    <= 1'b0;
    sel    <= 3'h0;
    duty   <= '0;
    pcnt   <= 6'h04;
    expc   <= 16'h0005;
    repeat (11) @(posedge clk_i);
    rstn_i <= 1'b1;
    cyc(2);
    t_step();
    t_alt();
    t_pause();
    t_sync();
    t_status();
    t_pwm();
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
  end
endmodule
